// file: verilog/nsis_core.sv
// Nibble-serial sequencer: moves, INCREMENT_SKIP_ZERO/DECREMENT_SKIP_ZERO with skip, load-accumulator with
// effective address. Assumes memory returns the word at O_MEM_ADDR on
// I_MEM_RDATA within the same clock, in time for the next edge.
//
// Behaviour
// - Arithmetic class with IR bit 10 set zeroes the destination operand.
// - Move fetch loads the sum into the buffer and the PC into MEMORY_BUFFER_OUTPUT_REG.
// - Restore flag strobes accumulator writes nibble by nibble next cycle.
// - Increment and decrement-skip take a fetch then an execute cycle.
// - End of time state zero sets address flag unless skipped, I/O or arithmetic.
// - Page-zero address field passes through the adder into MEMORY_BUFFER_OUTPUT_REG.
// - Execute first loads the address register, then MEMORY_BUFFER_OUTPUT_REG from memory.
// - The increment/decrement pass extends time state zero four clocks.
// - Address flag clears at the start of execute.
// - Decrement adds all ones with the subtract control asserted.
// - Increment injects a carry into the low nibble, subtract control low.
// - Execute state three writes memory, fills buffer, reloads PC into MEMORY_BUFFER_OUTPUT_REG.
// - The increment/decrement execute cycle arms the skip test for the next cycle.
// - Next cycle shifts the buffer out; any one blocks the skip.
// - Skip suppresses decoding and deferral; a new fetch follows.
// - Load-accumulator selects the low address field through the source path.
// - Page zero zeroes the destination; otherwise PC bits are added.
// - First two address nibbles add the displacement to the PC.
// - Negative displacement off page zero adds ones in the top two nibbles.
// - With the control low the adder passes its A operand.
// - Nibble phase pair counts 00, 10, 01, 11 for nibbles one to four.
`timescale 1ns/10ps
module nsis_core
(
   // Clock and reset.
   input  wire logic        I_CLK,
   input  wire logic        I_RST_B,
   // APB register port.
   input  wire logic        I_PSEL,
   input  wire logic        I_PENABLE,
   input  wire logic        I_PWRITE,
   input  wire logic [7:0]  I_PADDR,
   input  wire logic [31:0] I_PWDATA,
   output logic      [31:0] O_PRDATA,
   output logic             O_PREADY,
   output logic             O_PSLVERR,
   // Memory bus.
   input  wire logic [15:0] I_MEM_RDATA,
   output logic      [15:0] O_MEM_ADDR,
   output logic      [15:0] O_MEM_WDATA,
   output logic             O_MEM_WR,
   // Timing and status.
   output logic             O_NIBBLE_PHASE_A,
   output logic             O_NIBBLE_PHASE_B,
   output logic             O_ACC_WRITE_STROBE,
   output logic             O_SKIP
);

   nsis_pkg::nsis_major_t maj_q;
   logic        run_q;
   logic [1:0]  ts_q;
   logic [1:0]  nib_q;
   logic        cycle_extend_flag_q;
   logic [15:0] ir_q;
   logic [15:0] pc_q;
   logic [15:0] mbo_q;
   logic [15:0] acb_q;
   logic [15:0] ma_q;
   logic [15:0] mwd_q;
   logic [15:0] ac_q [4];
   logic        efa_q;
   logic        restore_q;
   logic [1:0]  rdst_q;
   logic        strb_q;
   logic [1:0]  snib_q;
   logic        skip_test_pending_q;
   logic        nz_q;
   logic        skip_q;
   logic        carry_q;
   logic        wr_q;
   logic        pready_q;
   logic        pslverr_q;
   logic [31:0] prdata_q;

   // Nibble n of a word; n = 0 is the least significant nibble.
   function automatic logic [3:0] nsis_nib(input logic [15:0] w, input logic [1:0] n);
      return w[{n, 2'h0} +: 4];
   endfunction

   // Word with nibble n replaced.
   function automatic logic [15:0] nsis_put(input logic [15:0] w, input logic [1:0] n,
                                            input logic [3:0] v);
      logic [15:0] r;
      r = w;
      r[{n, 2'h0} +: 4] = v;
      return r;
   endfunction

   function automatic logic nsis_is_alc(input logic [15:0] w);
      return w[15];
   endfunction

   function automatic logic nsis_is_io(input logic [15:0] w);
      return w[15:13] == nsis_pkg::NSIS_OP_IO;
   endfunction

   // Decode of the current cycle.
   logic fetch, exec, f_ts0, f_ts3, f_alc, f_ea, x_lead, x_pass, x_ts3;
   logic nib_end, cyc_end, increment_skip_zero, decrement_skip_zero, lda, pz, sext, skip_now, pc_to_buffer_gate;
   logic apb_wr, hit;
   assign fetch   = maj_q == nsis_pkg::NSIS_FETCH;
   assign exec    = maj_q == nsis_pkg::NSIS_EXEC;
   assign nib_end = run_q && nib_q == nsis_pkg::NSIS_NIB_LAST;
   assign cyc_end = nib_end && ts_q == nsis_pkg::NSIS_TS_LAST;
   assign f_ts0   = run_q && fetch && ts_q == nsis_pkg::NSIS_TS_ZERO;
   assign f_ts3   = run_q && fetch && ts_q == nsis_pkg::NSIS_TS_LAST;
   assign f_alc   = f_ts3 && !skip_q && nsis_is_alc(ir_q);
   assign f_ea    = f_ts3 && efa_q;
   assign x_lead  = run_q && exec && ts_q == nsis_pkg::NSIS_TS_ZERO && !cycle_extend_flag_q;
   assign x_pass  = run_q && exec && cycle_extend_flag_q;
   assign x_ts3   = run_q && exec && ts_q == nsis_pkg::NSIS_TS_LAST;
   assign increment_skip_zero     = ir_q[15:11] == nsis_pkg::NSIS_OP_ISZ;
   assign decrement_skip_zero     = ir_q[15:11] == nsis_pkg::NSIS_OP_DSZ;
   assign lda     = ir_q[15:13] == nsis_pkg::NSIS_OP_LDA;
   assign pz      = ir_q[9:8] == 2'h0;
   assign sext    = ir_q[nsis_pkg::NSIS_IR_SIGN] && !pz;
   // Zero result only if no earlier nibble and not this last one held a one.
   assign skip_now = skip_test_pending_q && !nz_q && nsis_nib(acb_q, nib_q) == 4'h0;
   // PC nibbles go to MEMORY_BUFFER_OUTPUT_REG in state three whenever MEMORY_BUFFER_OUTPUT_REG is not building an address.
   assign pc_to_buffer_gate = run_q && ts_q == nsis_pkg::NSIS_TS_LAST && (exec || !efa_q);

   // Operand selection for the shared nibble adder.
   logic       dest_mux_zero, adder_subtract_ctl, carry_in_increment, cin;
   logic [3:0] s_nib, d_nib;
   logic [4:0] sum5;
   always_comb
   begin
      s_nib              = 4'h0;
      d_nib              = nsis_nib(mbo_q, nib_q);
      dest_mux_zero      = 1'b0;
      adder_subtract_ctl = 1'b0;
      carry_in_increment = f_ts0 && nib_q == nsis_pkg::NSIS_NIB_FIRST;
      if (f_alc)
      begin
         s_nib              = nsis_nib(ac_q[ir_q[14:13]], nib_q);
         d_nib              = nsis_nib(ac_q[ir_q[12:11]], nib_q);
         dest_mux_zero      = ir_q[nsis_pkg::NSIS_IR_ZD];
         adder_subtract_ctl = 1'b1;
      end
      if (f_ea)
      begin
         // Low two nibbles carry the address field, upper ones the sign.
         if (nib_q < nsis_pkg::NSIS_NIB_HI)
            s_nib = nsis_nib({8'h00, ir_q[7:0]}, nib_q);
         else
            s_nib = {4{sext}};
         dest_mux_zero      = pz;
         adder_subtract_ctl = (nib_q < nsis_pkg::NSIS_NIB_HI) || sext;
      end
      if (x_pass)
      begin
         if (decrement_skip_zero)
         begin
            adder_subtract_ctl = 1'b1;
            s_nib              = 4'hf;
         end
         else
            carry_in_increment = nib_q == nsis_pkg::NSIS_NIB_FIRST;
      end
   end

   // Carry ripples from the low nibble upward between clocks.
   assign cin  = (nib_q == nsis_pkg::NSIS_NIB_FIRST) ? carry_in_increment : carry_q;
   // With the control low only the A operand reaches the sum.
   assign sum5 = {1'b0, dest_mux_zero ? 4'h0 : d_nib}
               + {1'b0, adder_subtract_ctl ? s_nib : 4'h0}
               + {4'h0, cin};

   // Time states, nibble phases and major state.
   always_ff @(posedge I_CLK or negedge I_RST_B)
   begin
      if (!I_RST_B)
      begin
         nib_q               <= nsis_pkg::NSIS_NIB_FIRST;
         ts_q                <= nsis_pkg::NSIS_TS_ZERO;
         maj_q               <= nsis_pkg::NSIS_FETCH;
         cycle_extend_flag_q <= 1'b0;
      end
      else if (run_q)
      begin
         nib_q <= nib_q + 2'h1;
         if (nib_q == nsis_pkg::NSIS_NIB_LAST)
         begin
            if (x_lead && (increment_skip_zero || decrement_skip_zero))
               cycle_extend_flag_q <= 1'b1;
            else if (cycle_extend_flag_q)
            begin
               cycle_extend_flag_q <= 1'b0;
               ts_q                <= nsis_pkg::NSIS_TS_ONE;
            end
            else if (ts_q == nsis_pkg::NSIS_TS_LAST)
            begin
               ts_q  <= nsis_pkg::NSIS_TS_ZERO;
               // Memory reference goes on to execute; all else fetches again.
               maj_q <= (fetch && efa_q) ? nsis_pkg::NSIS_EXEC
                                         : nsis_pkg::NSIS_FETCH;
            end
            else
               ts_q <= ts_q + 2'h1;
         end
      end
   end

   // Serial carry; dropped at each nibble group's end.
   always_ff @(posedge I_CLK or negedge I_RST_B)
   begin
      if (!I_RST_B)
         carry_q <= 1'b0;
      else
         carry_q <= run_q && !nib_end && sum5[4];
   end

   // Effective address flag.
   always_ff @(posedge I_CLK or negedge I_RST_B)
   begin
      if (!I_RST_B)
         efa_q <= 1'b0;
      else if (f_ts0 && nib_end)
         efa_q <= !skip_now && !nsis_is_io(I_MEM_RDATA) && !nsis_is_alc(I_MEM_RDATA);
      else if (fetch && cyc_end)
         efa_q <= 1'b0;
   end

   // Instruction register, loaded even on a skip; decoding is what is held off.
   always_ff @(posedge I_CLK or negedge I_RST_B)
   begin
      if (!I_RST_B)
         ir_q <= nsis_pkg::NSIS_WORD_RST;
      else if (f_ts0 && nib_end)
         ir_q <= I_MEM_RDATA;
   end

   // Address register takes MEMORY_BUFFER_OUTPUT_REG on the first clock of every cycle.
   always_ff @(posedge I_CLK or negedge I_RST_B)
   begin
      if (!I_RST_B)
         ma_q <= nsis_pkg::NSIS_WORD_RST;
      else if (run_q && ts_q == nsis_pkg::NSIS_TS_ZERO && !cycle_extend_flag_q
               && nib_q == nsis_pkg::NSIS_NIB_FIRST)
         ma_q <= mbo_q;
   end

   // Memory buffer output register.
   always_ff @(posedge I_CLK or negedge I_RST_B)
   begin
      if (!I_RST_B)
         mbo_q <= nsis_pkg::NSIS_WORD_RST;
      else if (apb_wr && I_PADDR == nsis_pkg::NSIS_REG_PC && !run_q)
         mbo_q <= I_PWDATA[15:0];
      else if (x_lead && nib_q == nsis_pkg::NSIS_NIB_LOAD)
         mbo_q <= I_MEM_RDATA;
      else if (x_pass || f_ea)
         mbo_q <= nsis_put(mbo_q, nib_q, sum5[3:0]);
      else if (pc_to_buffer_gate)
         mbo_q <= nsis_put(mbo_q, nib_q, nsis_nib(pc_q, nib_q));
   end

   // Program counter advances serially from MEMORY_BUFFER_OUTPUT_REG in every fetch.
   always_ff @(posedge I_CLK or negedge I_RST_B)
   begin
      if (!I_RST_B)
         pc_q <= nsis_pkg::NSIS_WORD_RST;
      else if (apb_wr && I_PADDR == nsis_pkg::NSIS_REG_PC && !run_q)
         pc_q <= I_PWDATA[15:0];
      else if (f_ts0)
         pc_q <= nsis_put(pc_q, nib_q, sum5[3:0]);
   end

   // Accumulator buffer collects adder output.
   always_ff @(posedge I_CLK or negedge I_RST_B)
   begin
      if (!I_RST_B)
         acb_q <= nsis_pkg::NSIS_WORD_RST;
      else if (f_alc || x_ts3)
         acb_q <= nsis_put(acb_q, nib_q, sum5[3:0]);
   end

   // Memory write copy is frozen at state three because MEMORY_BUFFER_OUTPUT_REG is refilled then.
   always_ff @(posedge I_CLK or negedge I_RST_B)
   begin
      if (!I_RST_B)
      begin
         wr_q  <= 1'b0;
         mwd_q <= nsis_pkg::NSIS_WORD_RST;
      end
      else
      begin
         wr_q <= x_ts3 && nib_q == nsis_pkg::NSIS_NIB_FIRST;
         if (x_ts3 && nib_q == nsis_pkg::NSIS_NIB_FIRST)
            mwd_q <= mbo_q;
      end
   end

   // Restore flag and its write strobe, one clock behind each nibble.
   always_ff @(posedge I_CLK or negedge I_RST_B)
   begin
      if (!I_RST_B)
      begin
         restore_q <= 1'b0;
         rdst_q    <= 2'h0;
         strb_q    <= 1'b0;
         snib_q    <= nsis_pkg::NSIS_NIB_FIRST;
      end
      else
      begin
         strb_q <= restore_q && run_q && ts_q == nsis_pkg::NSIS_TS_ZERO
                   && !cycle_extend_flag_q;
         snib_q <= nib_q;
         if (cyc_end && ((fetch && !skip_q && nsis_is_alc(ir_q)) || (exec && lda)))
         begin
            restore_q <= 1'b1;
            rdst_q    <= ir_q[12:11];
         end
         else if (nib_end && ts_q == nsis_pkg::NSIS_TS_ZERO)
            restore_q <= 1'b0;
      end
   end

   // Accumulators: written by the strobe, or by software while stopped.
   always_ff @(posedge I_CLK or negedge I_RST_B)
   begin
      if (!I_RST_B)
      begin
         for (int i = 0; i < 4; i++)
            ac_q[i] <= nsis_pkg::NSIS_WORD_RST;
      end
      else if (strb_q)
         ac_q[rdst_q] <= nsis_put(ac_q[rdst_q], snib_q, nsis_nib(acb_q, snib_q));
      else if (apb_wr && !run_q && I_PADDR >= nsis_pkg::NSIS_REG_AC0
               && I_PADDR <= nsis_pkg::NSIS_REG_AC3)
         ac_q[I_PADDR[3:2] - 2'h3] <= I_PWDATA[15:0];
   end

   // Skip test, nonzero latch and skip flag.
   always_ff @(posedge I_CLK or negedge I_RST_B)
   begin
      if (!I_RST_B)
      begin
         skip_test_pending_q <= 1'b0;
         nz_q                <= 1'b0;
         skip_q              <= 1'b0;
      end
      else
      begin
         if (exec && cyc_end && (increment_skip_zero || decrement_skip_zero))
            skip_test_pending_q <= 1'b1;
         else if (f_ts0 && nib_end)
            skip_test_pending_q <= 1'b0;
         if (nib_end)
            nz_q <= 1'b0;
         else if (f_ts0 && skip_test_pending_q && nsis_nib(acb_q, nib_q) != 4'h0)
            nz_q <= 1'b1;
         if (f_ts0 && nib_end)
            skip_q <= skip_now;
         else if (cyc_end)
            skip_q <= 1'b0;
      end
   end

   // APB slave: answers in the first access cycle; unmapped gets an error.
   assign apb_wr = I_PSEL && I_PENABLE && pready_q && I_PWRITE && !pslverr_q;
   assign hit    = I_PADDR[1:0] == 2'h0 && I_PADDR <= nsis_pkg::NSIS_REG_IR;
   always_ff @(posedge I_CLK or negedge I_RST_B)
   begin
      if (!I_RST_B)
      begin
         pready_q  <= 1'b0;
         pslverr_q <= 1'b0;
         prdata_q  <= nsis_pkg::NSIS_RDATA_RST;
      end
      else
      begin
         pready_q  <= I_PSEL && !I_PENABLE;
         pslverr_q <= I_PSEL && !I_PENABLE && !hit;
         if (I_PSEL && !I_PENABLE)
         begin
            unique case (I_PADDR)
               nsis_pkg::NSIS_REG_CTRL: prdata_q <= {31'h0, run_q};
               nsis_pkg::NSIS_REG_PC:   prdata_q <= {16'h0, pc_q};
               nsis_pkg::NSIS_REG_STAT: prdata_q <= {21'h0, maj_q, ts_q, nib_q,
                  cycle_extend_flag_q, efa_q, restore_q, skip_test_pending_q, nz_q, skip_q};
               nsis_pkg::NSIS_REG_ACB:  prdata_q <= {16'h0, acb_q};
               nsis_pkg::NSIS_REG_MA:   prdata_q <= {16'h0, ma_q};
               nsis_pkg::NSIS_REG_IR:   prdata_q <= {16'h0, ir_q};
               default:
                  prdata_q <= hit ? {16'h0, ac_q[I_PADDR[3:2] - 2'h3]}
                                  : nsis_pkg::NSIS_RDATA_RST;
            endcase
         end
      end
   end

   // Run control; stopping mid-cycle freezes the sequencer where it stands.
   always_ff @(posedge I_CLK or negedge I_RST_B)
   begin
      if (!I_RST_B)
         run_q <= 1'b0;
      else if (apb_wr && I_PADDR == nsis_pkg::NSIS_REG_CTRL)
         run_q <= I_PWDATA[nsis_pkg::NSIS_CTRL_RUN];
   end

   assign O_PRDATA           = prdata_q;
   assign O_PREADY           = pready_q;
   assign O_PSLVERR          = pslverr_q;
   assign O_MEM_ADDR         = ma_q;
   assign O_MEM_WDATA        = mwd_q;
   assign O_MEM_WR           = wr_q;
   assign O_NIBBLE_PHASE_A   = nib_q[0];
   assign O_NIBBLE_PHASE_B   = nib_q[1];
   assign O_ACC_WRITE_STROBE = strb_q;
   assign O_SKIP             = skip_q;

   // Checks on the sequencer.
   default clocking cb @(posedge I_CLK); endclocking
   default disable iff (!I_RST_B);

   chk_move_zero_dest:
      assert property (f_alc && ir_q[nsis_pkg::NSIS_IR_ZD] |-> dest_mux_zero && sum5[3:0]
                       == nsis_nib(ac_q[ir_q[14:13]], nib_q) + {3'h0, carry_q})
      else $error("Move did not zero the destination operand.");
   chk_move_pc_gate:
      assert property (f_alc |-> pc_to_buffer_gate)
      else $error("Move fetch did not gate PC into MEMORY_BUFFER_OUTPUT_REG.");
   // A software stop freezes the sequencer mid-strobe, so that case is not judged.
   chk_restore_strobe:
      assert property (disable iff (!I_RST_B || !run_q)
                       restore_q && f_ts0 && nib_q == 2'h0 |=> strb_q [*4] ##1 !strb_q)
      else $error("Accumulator write strobe not four clocks.");
   chk_two_cycle:
      assert property (f_ts3 && nib_end && efa_q && (increment_skip_zero || decrement_skip_zero) |=> exec)
      else $error("Skip instruction did not enter execute.");
   chk_efa_decode:
      assert property (f_ts0 && nib_end && !skip_now && !nsis_is_io(I_MEM_RDATA)
                       && !nsis_is_alc(I_MEM_RDATA) |=> efa_q)
      else $error("Address flag not set after memory reference fetch.");
   chk_ma_load:
      assert property (x_lead && nib_q == 2'h0 |=> ma_q == $past(mbo_q)
                       ##1 mbo_q == $past(I_MEM_RDATA))
      else $error("Execute did not load MA then MEMORY_BUFFER_OUTPUT_REG.");
   chk_extend_len:
      assert property (x_lead && nib_end && (increment_skip_zero || decrement_skip_zero) |=> cycle_extend_flag_q [*4]
                       ##1 !cycle_extend_flag_q)
      else $error("Time state zero not extended by four clocks.");
   chk_efa_clear:
      assert property ($rose(exec) |-> !efa_q)
      else $error("Address flag still set in execute.");
   chk_dec_ones:
      assert property (x_pass && decrement_skip_zero |-> adder_subtract_ctl && s_nib == 4'hf)
      else $error("Decrement did not add all ones.");
   chk_inc_carry:
      assert property (x_pass && increment_skip_zero && nib_q == 2'h0 |-> !adder_subtract_ctl && cin)
      else $error("Increment carry missing in low nibble.");
   chk_mem_write:
      assert property (x_ts3 && nib_q == 2'h0 |=> wr_q && mwd_q == $past(mbo_q))
      else $error("Execute state three memory write wrong.");
   chk_skip_arm:
      assert property (exec && cyc_end && (increment_skip_zero || decrement_skip_zero) |=> skip_test_pending_q)
      else $error("Skip test not armed.");
   chk_skip_zero:
      assert property (f_ts0 && nib_q == 2'h0 && skip_test_pending_q |=> ##3
                       skip_q == ($past(acb_q, 4) == 16'h0000))
      else $error("Skip decision does not match buffer zero test.");
   chk_skip_no_decode:
      assert property (skip_q |-> !efa_q && !f_alc)
      else $error("Skipped fetch still decoded.");

endmodule

// file: verilog/nsis_pkg.sv
// Constants and types shared by the nibble-serial instruction sequencer.
// Assumes a single 200 MHz clock and an APB register port with 32-bit data.
package nsis_pkg;

   // APB register byte offsets.
   localparam logic [7:0] NSIS_REG_CTRL = 8'h00;
   localparam logic [7:0] NSIS_REG_PC   = 8'h04;
   localparam logic [7:0] NSIS_REG_STAT = 8'h08;
   localparam logic [7:0] NSIS_REG_AC0  = 8'h0c;
   localparam logic [7:0] NSIS_REG_AC3  = 8'h18;
   localparam logic [7:0] NSIS_REG_ACB  = 8'h1c;
   localparam logic [7:0] NSIS_REG_MA   = 8'h20;
   localparam logic [7:0] NSIS_REG_IR   = 8'h24;

   // Values after reset.
   localparam logic [15:0] NSIS_WORD_RST  = 16'h0000;
   localparam logic [31:0] NSIS_RDATA_RST = 32'h0000_0000;

   // Field positions.
   localparam int NSIS_CTRL_RUN = 0;
   localparam int NSIS_IR_ZD    = 10;
   localparam int NSIS_IR_SIGN  = 7;

   // Cycle counts: four nibbles per time state, four time states per cycle.
   localparam logic [1:0] NSIS_NIB_FIRST = 2'h0;
   localparam logic [1:0] NSIS_NIB_LOAD  = 2'h1;
   localparam logic [1:0] NSIS_NIB_HI    = 2'h2;
   localparam logic [1:0] NSIS_NIB_LAST  = 2'h3;
   localparam logic [1:0] NSIS_TS_ZERO   = 2'h0;
   localparam logic [1:0] NSIS_TS_ONE    = 2'h1;
   localparam logic [1:0] NSIS_TS_LAST   = 2'h3;

   // Instruction encodings.
   localparam logic [4:0] NSIS_OP_ISZ = 5'h02;
   localparam logic [4:0] NSIS_OP_DSZ = 5'h03;
   localparam logic [2:0] NSIS_OP_LDA = 3'h1;
   localparam logic [2:0] NSIS_OP_IO  = 3'h3;

   typedef enum logic {NSIS_FETCH, NSIS_EXEC} nsis_major_t;

endpackage

// file: tb/nsis_mem_model.sv
// Core memory model behind the sequencer's memory bus.
// Assumes the sequencer's clock and a 256-word space.
`timescale 1ns/10ps
module nsis_mem_model
(
   // Clock.
   input  wire logic        i_clk,
   // Memory bus.
   input  wire logic [15:0] i_addr,
   input  wire logic [15:0] i_wdata,
   input  wire logic        i_wr,
   output logic      [15:0] o_rdata
);
   logic [15:0] mem [0:255];

   // The word follows the address at once, so the core finds it at the next edge.
   assign o_rdata = mem[i_addr[7:0]];

   // Upper address bits are ignored, so a stray address aliases low words.
   always @(posedge i_clk)
   begin
      if (i_wr)
         mem[i_addr[7:0]] <= i_wdata;
   end
endmodule

// file: tb/tb_nibble_serial_instruction_sequencer.sv
// Bench for the sequencer: APB tasks, a small program, expected results.
// Assumes the core, its package and the memory model are compiled first.
`timescale 1ns/10ps
module tb_nibble_serial_instruction_sequencer;
   logic        clk = 1'b0;
   logic        rst_b = 1'b0;
   logic        psel = 1'b0;
   logic        pen = 1'b0;
   logic        pwr = 1'b0;
   logic [7:0]  pa = 8'h00;
   logic [31:0] pwd = 32'h0000_0000;
   logic [31:0] prd, rd;
   logic        rdy, slverr, err, wr, ph_a, ph_b, stb, skip;
   logic        seen = 1'b0;
   logic        stb_seen = 1'b0;
   logic [15:0] mrd, ma, mwd;
   logic [1:0]  ph;
   int          bad_count = 0;
   int          n_compared = 0;

   // Free-running 200 MHz clock.
   always #2.5 clk = ~clk;

   nsis_core DUT (.I_CLK(clk), .I_RST_B(rst_b), .I_PSEL(psel), .I_PENABLE(pen),
      .I_PWRITE(pwr), .I_PADDR(pa), .I_PWDATA(pwd), .O_PRDATA(prd), .O_PREADY(rdy),
      .O_PSLVERR(slverr), .I_MEM_RDATA(mrd), .O_MEM_ADDR(ma), .O_MEM_WDATA(mwd),
      .O_MEM_WR(wr), .O_NIBBLE_PHASE_A(ph_a), .O_NIBBLE_PHASE_B(ph_b),
      .O_ACC_WRITE_STROBE(stb), .O_SKIP(skip));
   nsis_mem_model MEM (.i_clk(clk), .i_addr(ma), .i_wdata(mwd), .i_wr(wr), .o_rdata(mrd));

   // A skip is a short level, so it is remembered for the final check.
   always @(posedge clk)
   begin
      if (skip === 1'b1)
         seen <= 1'b1;
      if (stb === 1'b1)
         stb_seen <= 1'b1;
   end

   task automatic summarize();
      $display("compared %0d, mismatches %0d", n_compared, bad_count);
      if (bad_count == 0 && n_compared > 0)
         $display("All tests passed");
      else
         $display("Some tests failed");
      $finish;
   endtask

   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      n_compared++;
      if (got !== exp)
      begin
         bad_count++;
         $display("wrong value at %0t: got %h expected %h", $time, got, exp);
      end
   endtask

   // One APB transfer; the answer is taken at the rising edge where ready is high.
   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      logic done;
      done = 1'b0;
      @(posedge clk);
      psel <= 1'b1;
      pwr  <= w;
      pa   <= a;
      pwd  <= d;
      @(posedge clk);
      pen <= 1'b1;
      for (int i = 0; i < 16 && !done; i++)
      begin
         @(posedge clk);
         done = (rdy === 1'b1);
         rd   = prd;
         err  = slverr;
      end
      psel <= 1'b0;
      pen  <= 1'b0;
      if (!done)
      begin
         bad_count++;
         summarize();
      end
   endtask

   initial
   begin
      // Filler moves AC0 onto itself, so the run may stop anywhere.
      for (int i = 0; i < 256; i++)
         MEM.mem[i] = 16'h8400;
      MEM.mem[8'h10] = 16'h1040; // Increment a word at all ones.
      MEM.mem[8'h11] = 16'h2042; // Load AC0; must be skipped.
      MEM.mem[8'h12] = 16'h1841; // Decrement two to one, no skip.
      MEM.mem[8'h13] = 16'h3841; // Load AC3 from page zero.
      MEM.mem[8'h14] = 16'hf400; // Move AC3 into AC2.
      MEM.mem[8'h15] = 16'h29fd; // Load AC1 three words back, relative.
      MEM.mem[8'h40] = 16'hffff;
      MEM.mem[8'h41] = 16'h0002;
      MEM.mem[8'h42] = 16'h5555;
      repeat (16) @(posedge clk);
      rst_b <= 1'b1;
      apb(1'b0, nsis_pkg::NSIS_REG_PC, 32'h0);
      chk(rd, nsis_pkg::NSIS_RDATA_RST);
      apb(1'b0, nsis_pkg::NSIS_REG_STAT, 32'h0);
      chk(rd, nsis_pkg::NSIS_RDATA_RST);
      apb(1'b0, 8'h40, 32'h0);
      chk({rd[30:0], err}, 32'h1);
      $display("reset and decode test done");
      apb(1'b1, nsis_pkg::NSIS_REG_PC, 32'h10);
      apb(1'b1, nsis_pkg::NSIS_REG_CTRL, 32'h1);
      apb(1'b1, nsis_pkg::NSIS_REG_AC0, 32'h1234);
      @(negedge clk);
      ph = {ph_b, ph_a};
      for (int i = 0; i < 8; i++)
      begin
         @(negedge clk);
         chk({ph_b, ph_a}, {30'h0, ph + 2'h1});
         ph = {ph_b, ph_a};
      end
      repeat (400) @(posedge clk);
      apb(1'b1, nsis_pkg::NSIS_REG_CTRL, 32'h0);
      repeat (40) @(posedge clk);
      $display("program run done");
      apb(1'b0, nsis_pkg::NSIS_REG_AC0, 32'h0);
      chk(rd, 32'h0);
      apb(1'b0, 8'h10, 32'h0);
      chk(rd, 32'h1841);
      apb(1'b0, 8'h14, 32'h0);
      chk(rd, 32'h1);
      apb(1'b0, nsis_pkg::NSIS_REG_AC3, 32'h0);
      chk(rd, 32'h1);
      chk(MEM.mem[8'h40], 16'h0);
      chk(MEM.mem[8'h41], 16'h1);
      chk(seen, 1'b1);
      chk(stb_seen, 1'b1);
      $display("result test done");
      summarize();
   end
endmodule
